// file: design/ssis_pkg.sv
// Package of constants and types for the sequence input selector.
package ssis_pkg;

  // ****************************************
  // Terminal assignment codes
  // ****************************************
  localparam logic [4:0] FN_RUN = 5'h01;    // Servo on.
  localparam logic [4:0] FN_AR0 = 5'h09;    // Anti-resonance select bit 0.
  localparam logic [4:0] FN_AR1 = 5'h0a;    // Anti-resonance select bit 1.
  localparam logic [4:0] FN_INH = 5'h0b;    // Command pulse inhibit.
  localparam logic [4:0] FN_CP0 = 5'h0c;    // Pulse compensation select bit 0.
  localparam logic [4:0] FN_CP1 = 5'h0d;    // Pulse compensation select bit 1.
  localparam logic [4:0] FN_MSW = 5'h0e;    // Control mode switching.
  localparam logic [4:0] FN_FWD = 5'h0f;    // Jog forward.
  localparam logic [4:0] FN_REV = 5'h10;    // Jog reverse.
  localparam logic [4:0] FN_SS0 = 5'h11;    // Speed step select bit 0.
  localparam logic [4:0] FN_SS1 = 5'h12;    // Speed step select bit 1.

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_MODE = 8'h00;      // Control mode parameter.
  localparam logic [7:0] OFS_ANTIRES = 8'h04;   // Four anti-resonance words.
  localparam logic [7:0] OFS_COMP = 8'h14;      // Four compensation words.
  localparam logic [7:0] OFS_STEP = 8'h24;      // Three step speed words.
  localparam logic [7:0] OFS_GAIN = 8'h30;      // Analog speed gain ratio.
  localparam logic [7:0] OFS_MAXSPD = 8'h34;    // Maximum motor speed.
  localparam logic [7:0] OFS_MAP_LO = 8'h38;    // Terminals 0 to 3 codes.
  localparam logic [7:0] OFS_MAP_HI = 8'h3c;    // Terminals 4 to 7 codes.
  localparam logic [7:0] OFS_STATUS = 8'h40;    // Live selection status.
  localparam logic [7:0] OFS_SPEED = 8'h44;     // Live jog speed.

  // ****************************************
  // Reset values and limits
  // ****************************************
  localparam logic [2:0] RST_MODE = 3'h0;       // Fixed position control.
  localparam logic [15:0] FREQ_OFF = 16'h07d0;  // 200.0 Hz in 0.1 Hz units.
  localparam logic [15:0] RST_COMP = 16'h0001;  // Unity compensation.
  localparam logic [15:0] RST_STEP = 16'h0064;  // Step speed in r/min.
  localparam logic [15:0] RST_GAIN = 16'h1000;  // Ratio 1.0, 12 fraction bits.
  localparam logic [15:0] RST_MAXSPD = 16'h0bb8; // Maximum speed in r/min.
  localparam int GAIN_FRAC = 12;                // Fraction bits of the gain.
  localparam int ANA_FRAC = 13;                 // Full scale of a 14-bit code.
  localparam int ANA_W = 14;                    // Analog code width.

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {MODE_POS, MODE_SPD, MODE_TRQ} ssis_mode_type;
  typedef enum logic [1:0] {JOG_IDLE, JOG_FWD, JOG_REV} ssis_jog_type;

endpackage

// file: design/ssis_sync.sv
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/100ps
module ssis_sync #(
  parameter int W = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Asynchronous inputs and filtered outputs.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // ****************************************
  // Synchroniser stages
  // ****************************************
  logic [W-1:0] s1_r, s2_r, s3_r; // Stage one is read only by stage two.
  logic [W-1:0] q_nxt;            // Next filtered value.

  // A bit changes only once the second and third stages agree.
  always_comb begin
    for (int i = 0; i < W; i++) begin
      q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q[i];
    end
  end

  // Register the stages and the filtered value.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q <= q_nxt;
    end
  end

endmodule

// file: design/ssis_selector.sv
// Sequence input selector: terminal decode, selections, jog and APB registers.
// Summary of operation
// - Two bits pick anti-resonance word 0-3.
// - Unmapped select bits leave word 0 active.
// - Frequency 200.0 Hz disables anti-resonance.
// - Select bits use codes 9 and 10.
// - Inhibit blocks pulses, enables jog in position.
// - Unmapped inhibit means pulses accepted under servo-on in position.
// - Two bits pick compensation word 0-3.
// - Compensation bits use codes 12 and 13.
// - Mode values 0-2 fix mode, ignore switch.
// - Mode values 3-5 let switch pick mode.
// - Jog runs at the selected analog or step speed when asserted, stops at once when released.
// - Both jogs: stop, or keep motion in position.
// - Torque mode follows torque command under servo-on, level jog.
// - Jogs use codes 15 and 16, unmapped off.
// - Step bits pick analog or step speeds.
// - Analog full scale gives max speed times gain.
// - Analog speed command has 14-bit resolution.
`timescale 1ns/100ps
module ssis_selector
  import ssis_pkg::*;
#(
  parameter int NUM_TERM = 8
) (
  // Clock and reset.
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // APB register port.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Sequence input terminals and analog commands.
  input wire logic [NUM_TERM-1:0] SEQ_IN,
  input wire logic [ANA_W-1:0] SPEED_CMD,
  input wire logic [ANA_W-1:0] TORQUE_CMD,
  // Selected values towards the servo loop.
  output logic [15:0] ANTIRES_FREQ,
  output logic ANTIRES_EN,
  output logic [15:0] COMP_FACTOR,
  output logic [1:0] CTRL_MODE,
  output logic PULSE_ACCEPT,
  output logic [1:0] JOG_DIR,
  output logic [15:0] JOG_SPEED,
  output logic [ANA_W-1:0] TORQUE_OUT
);

  // ****************************************
  // Decode helpers
  // ****************************************
  // True when any terminal mapped to the code is active; unmapped reads off.
  function automatic logic fn_on(input logic [4:0] code, input logic [NUM_TERM-1:0] lv,
                                 input logic [NUM_TERM-1:0][4:0] map);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_TERM; i++) begin
      hit = hit | (lv[i] & (map[i] == code));
    end
    return hit;
  endfunction

  // True when the byte address selects the given register word.
  function automatic logic at(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // ****************************************
  // Input synchronisation
  // ****************************************
  logic [NUM_TERM-1:0] term_lv;  // Filtered terminal levels.
  logic [ANA_W-1:0] spd_code;    // Filtered analog speed code.
  logic [ANA_W-1:0] trq_code;    // Filtered analog torque code.

  // Every terminal and analog input passes the three-stage filter; the APB signals do not.
  ssis_sync #(.W(NUM_TERM + 2 * ANA_W)) u_sync (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .d({SEQ_IN, SPEED_CMD, TORQUE_CMD}),
    .q({term_lv, spd_code, trq_code})
  );

  // ****************************************
  // Parameter registers
  // ****************************************
  logic [2:0] mode_par_r, mode_par_nxt;          // Control mode parameter.
  logic [3:0][15:0] antires_r, antires_nxt;      // Anti-resonance words.
  logic [3:0][15:0] comp_r, comp_nxt;            // Compensation words.
  logic [3:1][15:0] step_r, step_nxt;            // Step speed words.
  logic [15:0] gain_r, gain_nxt;                 // Analog gain ratio.
  logic [15:0] maxspd_r, maxspd_nxt;             // Maximum speed.
  logic [NUM_TERM-1:0][4:0] map_r, map_nxt;      // Terminal assignment codes.
  logic [31:0] rdata_r, rdata_nxt;               // Read data latch.
  logic err_r, err_nxt;                          // Error for the access.
  logic wr_en;                                   // Write takes effect.
  logic hit;                                     // Address is mapped.
  logic ro_hit;                                  // Address is read-only.
  logic [31:0] status_w;                         // Live status word.

  assign wr_en = PSEL & PENABLE & PWRITE & ~err_r;
  assign PREADY = PSEL & PENABLE;
  assign PRDATA = rdata_r;
  assign PSLVERR = PSEL & PENABLE & err_r;

  // Decode the address of the current transfer.
  always_comb begin
    ro_hit = at(PADDR, OFS_STATUS) | at(PADDR, OFS_SPEED);
    hit = ro_hit | at(PADDR, OFS_MODE) | at(PADDR, OFS_GAIN) | at(PADDR, OFS_MAXSPD)
        | at(PADDR, OFS_MAP_LO) | at(PADDR, OFS_MAP_HI);
    for (int k = 0; k < 4; k++) begin
      hit = hit | at(PADDR, OFS_ANTIRES + 8'(4 * k)) | at(PADDR, OFS_COMP + 8'(4 * k));
    end
    for (int k = 1; k < 4; k++) begin
      hit = hit | at(PADDR, OFS_STEP + 8'(4 * (k - 1)));
    end
  end

  // Setup phase latches read data and the error answer; access writes.
  always_comb begin
    mode_par_nxt = mode_par_r;
    antires_nxt = antires_r;
    comp_nxt = comp_r;
    step_nxt = step_r;
    gain_nxt = gain_r;
    maxspd_nxt = maxspd_r;
    map_nxt = map_r;
    rdata_nxt = rdata_r;
    err_nxt = err_r;
    if (PSEL && !PENABLE) begin
      // Unmapped addresses and writes to live words are refused.
      err_nxt = ~hit | (PWRITE & ro_hit);
      rdata_nxt = '0;
      if (!PWRITE) begin
        if (at(PADDR, OFS_MODE)) rdata_nxt = {29'h0, mode_par_r};
        if (at(PADDR, OFS_GAIN)) rdata_nxt = {16'h0, gain_r};
        if (at(PADDR, OFS_MAXSPD)) rdata_nxt = {16'h0, maxspd_r};
        if (at(PADDR, OFS_STATUS)) rdata_nxt = status_w;
        if (at(PADDR, OFS_SPEED)) rdata_nxt = {16'h0, JOG_SPEED};
        for (int k = 0; k < 4; k++) begin
          if (at(PADDR, OFS_ANTIRES + 8'(4 * k))) rdata_nxt = {16'h0, antires_r[k]};
          if (at(PADDR, OFS_COMP + 8'(4 * k))) rdata_nxt = {16'h0, comp_r[k]};
          if (k < NUM_TERM) begin
            if (at(PADDR, OFS_MAP_LO)) rdata_nxt[8*k +: 5] = map_r[k];
          end
          if (k + 4 < NUM_TERM) begin
            if (at(PADDR, OFS_MAP_HI)) rdata_nxt[8*k +: 5] = map_r[k+4];
          end
        end
        for (int k = 1; k < 4; k++) begin
          if (at(PADDR, OFS_STEP + 8'(4 * (k - 1)))) rdata_nxt = {16'h0, step_r[k]};
        end
      end
    end
    if (wr_en) begin
      if (at(PADDR, OFS_MODE)) mode_par_nxt = PWDATA[2:0];
      if (at(PADDR, OFS_GAIN)) gain_nxt = PWDATA[15:0];
      if (at(PADDR, OFS_MAXSPD)) maxspd_nxt = PWDATA[15:0];
      for (int k = 0; k < 4; k++) begin
        if (at(PADDR, OFS_ANTIRES + 8'(4 * k))) antires_nxt[k] = PWDATA[15:0];
        if (at(PADDR, OFS_COMP + 8'(4 * k))) comp_nxt[k] = PWDATA[15:0];
        if (k < NUM_TERM && at(PADDR, OFS_MAP_LO)) map_nxt[k] = PWDATA[8*k +: 5];
        if (k + 4 < NUM_TERM && at(PADDR, OFS_MAP_HI)) map_nxt[k+4] = PWDATA[8*k +: 5];
      end
      for (int k = 1; k < 4; k++) begin
        if (at(PADDR, OFS_STEP + 8'(4 * (k - 1)))) step_nxt[k] = PWDATA[15:0];
      end
    end
  end

  // Register the parameter file; all terminals start unassigned.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      mode_par_r <= RST_MODE;
      antires_r <= {4{FREQ_OFF}};
      comp_r <= {4{RST_COMP}};
      step_r <= {3{RST_STEP}};
      gain_r <= RST_GAIN;
      maxspd_r <= RST_MAXSPD;
      map_r <= '0;
      rdata_r <= '0;
      err_r <= 1'b0;
    end else begin
      mode_par_r <= mode_par_nxt;
      antires_r <= antires_nxt;
      comp_r <= comp_nxt;
      step_r <= step_nxt;
      gain_r <= gain_nxt;
      maxspd_r <= maxspd_nxt;
      map_r <= map_nxt;
      rdata_r <= rdata_nxt;
      err_r <= err_nxt;
    end
  end

  // ****************************************
  // Function decode and selection
  // ****************************************
  logic f_run, f_inh, f_msw, f_fwd, f_rev; // Decoded function levels.
  logic [1:0] ar_sel, cp_sel, ss_sel;       // Decoded two-bit selections.
  logic fwd_d_r;                            // Previous jog forward level.
  logic rev_d_r;                            // Previous jog reverse level.
  ssis_mode_type mode_now;                  // Mode picked this cycle.
  ssis_jog_type jog_r, jog_nxt;             // Jog motion state.
  logic signed [47:0] ana_prod;             // Analog code times speed and gain.
  logic [15:0] ana_spd;                     // Scaled analog speed.
  logic [15:0] spd_pick;                    // Selected speed magnitude.
  logic [15:0] ar_nxt, cp_nxt, spd_nxt;     // Next output words.
  logic [ANA_W-1:0] trq_nxt;                // Next torque output.
  logic pulse_nxt;                          // Next pulse acceptance.

  always_comb begin
    f_run = fn_on(FN_RUN, term_lv, map_r);
    f_inh = fn_on(FN_INH, term_lv, map_r);
    f_msw = fn_on(FN_MSW, term_lv, map_r);
    f_fwd = fn_on(FN_FWD, term_lv, map_r);
    f_rev = fn_on(FN_REV, term_lv, map_r);
    ar_sel = {fn_on(FN_AR1, term_lv, map_r), fn_on(FN_AR0, term_lv, map_r)};
    cp_sel = {fn_on(FN_CP1, term_lv, map_r), fn_on(FN_CP0, term_lv, map_r)};
    ss_sel = {fn_on(FN_SS1, term_lv, map_r), fn_on(FN_SS0, term_lv, map_r)};
  end

  // Mode from the parameter; the switch only counts for values 3 to 5.
  always_comb begin
    case (mode_par_r)
      3'h1: mode_now = MODE_SPD;
      3'h2: mode_now = MODE_TRQ;
      3'h3: mode_now = f_msw ? MODE_SPD : MODE_POS;
      3'h4: mode_now = f_msw ? MODE_TRQ : MODE_POS;
      3'h5: mode_now = f_msw ? MODE_TRQ : MODE_SPD;
      default: mode_now = MODE_POS;
    endcase
  end

  // Jog state: edge start in position, level control elsewhere.
  always_comb begin
    jog_nxt = jog_r;
    if (mode_now == MODE_POS) begin
      // Jog needs the inhibit asserted by the host first.
      if (!f_inh) begin
        jog_nxt = JOG_IDLE;
      end else begin
        case (jog_r)
          JOG_IDLE: begin
            if (f_fwd && !fwd_d_r && !f_rev) jog_nxt = JOG_FWD;
            else if (f_rev && !rev_d_r && !f_fwd) jog_nxt = JOG_REV;
          end
          JOG_FWD: if (!f_fwd) jog_nxt = JOG_IDLE;
          JOG_REV: if (!f_rev) jog_nxt = JOG_IDLE;
          default: jog_nxt = JOG_IDLE;
        endcase
      end
    end else begin
      // Levels decide directly; both together stop the motor.
      case ({f_fwd, f_rev})
        2'b10: jog_nxt = JOG_FWD;
        2'b01: jog_nxt = JOG_REV;
        default: jog_nxt = JOG_IDLE;
      endcase
    end
  end

  // Speed: analog command scaled by maximum speed and gain, or a step.
  always_comb begin
    ana_prod = $signed(spd_code) * $signed({1'b0, maxspd_r}) * $signed({1'b0, gain_r});
    ana_spd = 16'(ana_prod >>> (ANA_FRAC + GAIN_FRAC));
    spd_pick = (ss_sel == 2'b00) ? ana_spd : step_r[ss_sel];
    case (jog_nxt)
      JOG_FWD: spd_nxt = spd_pick;
      JOG_REV: spd_nxt = 16'(-spd_pick);
      default: spd_nxt = 16'h0000;
    endcase
    ar_nxt = antires_r[ar_sel];
    cp_nxt = comp_r[cp_sel];
    trq_nxt = (mode_now == MODE_TRQ && f_run) ? trq_code : '0;
    pulse_nxt = (mode_now == MODE_POS) & f_run & ~f_inh;
  end

  // Outputs change only on the clock, so each selection is glitch free.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      jog_r <= JOG_IDLE;
      fwd_d_r <= 1'b0;
      rev_d_r <= 1'b0;
      ANTIRES_FREQ <= FREQ_OFF;
      COMP_FACTOR <= RST_COMP;
      CTRL_MODE <= MODE_POS;
      PULSE_ACCEPT <= 1'b0;
      JOG_SPEED <= 16'h0000;
      TORQUE_OUT <= '0;
    end else begin
      jog_r <= jog_nxt;
      fwd_d_r <= f_fwd;
      rev_d_r <= f_rev;
      ANTIRES_FREQ <= ar_nxt;
      COMP_FACTOR <= cp_nxt;
      CTRL_MODE <= mode_now;
      PULSE_ACCEPT <= pulse_nxt;
      JOG_SPEED <= spd_nxt;
      TORQUE_OUT <= trq_nxt;
    end
  end

  assign ANTIRES_EN = (ANTIRES_FREQ != FREQ_OFF);
  assign JOG_DIR = {jog_r == JOG_REV, jog_r == JOG_FWD};
  assign status_w = {20'h0, ss_sel, cp_sel, ar_sel, ANTIRES_EN, PULSE_ACCEPT,
                     JOG_DIR, CTRL_MODE};

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  chk_antires_pick: assert property ($stable(ar_sel) && $stable(antires_r) |=>
    ANTIRES_FREQ == $past(antires_r[ar_sel])) else $error("anti-resonance word mismatch");
  chk_antires_unmapped: assert property (ar_sel == 2'b00 |=>
    ANTIRES_FREQ == $past(antires_r[0])) else $error("word 0 not active");
  chk_antires_off: assert property (ANTIRES_FREQ == FREQ_OFF |-> !ANTIRES_EN)
    else $error("anti-resonance enabled at off frequency");
  chk_pulse_gate: assert property (f_inh |=> !PULSE_ACCEPT)
    else $error("pulses accepted while inhibited");
  chk_comp_pick: assert property ($stable(cp_sel) && $stable(comp_r) |=>
    COMP_FACTOR == $past(comp_r[cp_sel])) else $error("compensation word mismatch");
  chk_fixed_mode: assert property (mode_par_r == 3'h1 |=> CTRL_MODE == MODE_SPD)
    else $error("fixed speed mode not held");
  chk_switch_mode: assert property (mode_par_r == 3'h5 && f_msw |=>
    CTRL_MODE == MODE_TRQ) else $error("switch did not select torque");
  chk_pos_opposite: assert property (mode_now == MODE_POS && f_inh && jog_r == JOG_FWD
    && f_fwd |=> jog_r == JOG_FWD) else $error("position jog lost direction");
  chk_level_both: assert property (mode_now != MODE_POS && f_fwd && f_rev |=>
    jog_r == JOG_IDLE ##0 JOG_SPEED == 16'h0000) else $error("level jog did not stop");
  chk_jog_release: assert property (jog_r == JOG_FWD && !f_fwd && !f_rev |=>
    jog_r == JOG_IDLE) else $error("jog continued after release");
  chk_step_speed: assert property (jog_nxt == JOG_FWD && ss_sel == 2'b11 |=>
    JOG_SPEED == $past(step_r[3])) else $error("step speed 3 not used");

  cov_pos_jog: cover property (mode_now == MODE_POS && jog_r == JOG_IDLE ##1 jog_r == JOG_FWD);
  cov_level_stop: cover property (mode_now == MODE_SPD && f_fwd && f_rev);
  cov_antires3: cover property (ar_sel == 2'b11 ##1 ANTIRES_EN);
  cov_mode_switch: cover property (mode_par_r == 3'h4 && f_msw);

endmodule

// file: verif/ssis_host_model.sv
// Host controller model that drives the sequence input terminals.
`timescale 1ns/100ps
module ssis_host_model (
  // Clock.
  input wire logic clk,
  // Terminal levels towards the selector.
  output logic [7:0] seq_in
);
  // ****************************************
  // Function levels and terminal wiring
  // ****************************************
  logic [31:0] fn_lvl;   // Level of each function code; code 0 stays low.
  logic [4:0] map_r [8]; // Function code carried by each terminal.

  // Everything starts released and unwired.
  initial begin
    fn_lvl = '0;
    foreach (map_r[k]) map_r[k] = 5'h00;
  end

  // Each terminal shows the level of the function that it carries.
  always_comb begin
    for (int k = 0; k < 8; k++) seq_in[k] = fn_lvl[map_r[k]];
  end

  // Sets one function level; called just after a rising edge.
  task automatic set_fn(input int code, input logic v);
    fn_lvl[code] <= v;
  endtask

  // Loads the same terminal wiring that the selector was given.
  task automatic set_map(input logic [31:0] lo, input logic [31:0] hi);
    for (int k = 0; k < 4; k++) begin
      map_r[k] <= lo[8*k+:5];
      map_r[k+4] <= hi[8*k+:5];
    end
  endtask

  // A manual jog in position control raises the inhibit first.
  task automatic jog_pos(input int code);
    fn_lvl[11] <= 1'b1;
    repeat (6) @(posedge clk);
    fn_lvl[code] <= 1'b1;
  endtask
endmodule

// file: verif/testbench.sv
// Self-checking bench for the sequence input selector.
`timescale 1ns/100ps
module testbench
  import ssis_pkg::*;
;
  // ****************************************
  // Signals
  // ****************************************
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, er, ar_en, pacc;
  logic [7:0] paddr, seq_in;
  logic [31:0] pwdata, prdata, rd;
  logic [13:0] spd_cmd, trq_cmd, tq_out;
  logic [15:0] ar_freq, comp, jspd, g, e;
  logic [1:0] mode, jdir;
  logic [15:0] w [11]; // Anti-resonance 0-3, compensation 4-7, steps 8-10.
  int bad_count, cmp_count;

  ssis_host_model host (.clk(clk), .seq_in(seq_in));
  ssis_selector #(.NUM_TERM(8)) DUT (.CORE_CLK(clk), .RST_B(rst_b), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SEQ_IN(seq_in), .SPEED_CMD(spd_cmd),
    .TORQUE_CMD(trq_cmd), .ANTIRES_FREQ(ar_freq), .ANTIRES_EN(ar_en), .COMP_FACTOR(comp),
    .CTRL_MODE(mode), .PULSE_ACCEPT(pacc), .JOG_DIR(jdir), .JOG_SPEED(jspd),
    .TORQUE_OUT(tq_out));

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************
  // Tasks and expectation functions
  // ****************************************
  // Compares one value and counts it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Drives one function level at a rising edge.
  task automatic fn(input int c, input logic v);
    @(posedge clk);
    host.set_fn(c, v);
  endtask

  // Lets the input filter and the output registers catch up.
  task automatic settle();
    repeat (6) @(posedge clk);
    #1;
  endtask

  // Mode that a mode parameter and the switch input should give.
  function automatic logic [1:0] exp_mode(input int m, input logic sw);
    case (m)
      0, 1, 2: return 2'(m);
      3: return sw ? 2'h1 : 2'h0;
      4: return sw ? 2'h2 : 2'h0;
      default: return sw ? 2'h2 : 2'h1;
    endcase
  endfunction

  // Scaled analog speed: full scale times maximum speed times gain.
  function automatic logic [15:0] exp_ana(input logic [13:0] c, input logic [15:0] gn);
    longint p;
    p = longint'($signed(c)) * longint'(RST_MAXSPD) * longint'(gn);
    return p[40:25];
  endfunction

  // Verdict and end of run.
  task automatic finish_test();
    if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    #400000;
    bad_count++;
    finish_test();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {psel, penable, pwrite, rst_b} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    spd_cmd = 14'h0;
    trq_cmd = 14'h0;
    void'($urandom(32'h45fd));
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    settle();
    chk(ar_freq, FREQ_OFF);
    chk(ar_en, 0);
    chk(comp, RST_COMP);
    foreach (w[k]) w[k] = 16'($urandom_range(1, 16'h7fff));
    w[2] = FREQ_OFF;
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, OFS_ANTIRES + 8'(4 * k), 32'(w[k]));
      apb(1'b1, OFS_COMP + 8'(4 * k), 32'(w[k+4]));
    end
    fn(9, 1'b1);
    fn(10, 1'b1);
    fn(1, 1'b1);
    settle();
    chk(ar_freq, w[0]);
    chk(pacc, 0);
    apb(1'b1, OFS_MAP_LO, 32'h0d0c0a09);
    apb(1'b1, OFS_MAP_HI, 32'h1100010e);
    host.set_map(32'h0d0c0a09, 32'h1100010e);
    fn(11, 1'b1);
    settle();
    chk(pacc, 1);
    for (int s = 0; s < 4; s++) begin
      e = 16'($urandom_range(0, 3));
      fn(9, s[0]);
      fn(10, s[1]);
      fn(12, e[0]);
      fn(13, e[1]);
      settle();
      chk(ar_freq, w[s]);
      chk(ar_en, w[s] !== FREQ_OFF);
      chk(comp, w[4+e[1:0]]);
    end
    for (int m = 0; m < 6; m++) begin
      for (int sw = 0; sw < 2; sw++) begin
        apb(1'b1, OFS_MODE, 32'(m));
        fn(14, sw[0]);
        settle();
        chk(mode, exp_mode(m, sw[0]));
      end
    end
    apb(1'b1, OFS_MAP_LO, 32'h1211100f);
    apb(1'b1, OFS_MAP_HI, 32'h000b010e);
    host.set_map(32'h1211100f, 32'h000b010e);
    apb(1'b1, OFS_MODE, 32'h0);
    settle();
    chk(pacc, 0);
    fn(11, 1'b0);
    settle();
    chk(pacc, 1);
    fn(15, 1'b1);
    settle();
    chk(jdir, 0);
    fn(15, 1'b0);
    @(posedge clk);
    host.jog_pos(15);
    settle();
    chk(jdir, 2'h1);
    fn(16, 1'b1);
    settle();
    chk(jdir, 2'h1);
    fn(15, 1'b0);
    fn(16, 1'b0);
    settle();
    chk(jdir, 0);
    @(posedge clk);
    host.jog_pos(16);
    settle();
    chk(jdir, 2'h2);
    fn(16, 1'b0);
    g = 16'($urandom_range(16'h0100, 16'h1000));
    apb(1'b1, OFS_GAIN, 32'(g));
    apb(1'b1, OFS_MODE, 32'h1);
    for (int j = 1; j < 4; j++) apb(1'b1, OFS_STEP + 8'(4 * (j - 1)), 32'(w[7+j]));
    for (int j = 0; j < 4; j++) begin
      @(posedge clk);
      spd_cmd <= 14'($urandom);
      fn(17, j[0]);
      fn(18, j[1]);
      fn(15, 1'b1);
      settle();
      e = (j == 0) ? exp_ana(spd_cmd, g) : w[7+j];
      chk(jdir, 2'h1);
      chk(jspd, e);
      fn(15, 1'b0);
      fn(16, 1'b1);
      settle();
      chk(jdir, 2'h2);
      chk(jspd, 16'(-e));
      fn(15, 1'b1);
      settle();
      chk(jdir, 0);
      fn(15, 1'b0);
      fn(16, 1'b0);
    end
    apb(1'b1, OFS_MODE, 32'h2);
    trq_cmd <= 14'($urandom);
    settle();
    chk(tq_out, trq_cmd);
    apb(1'b0, 8'h80, 32'h0);
    chk(er, 1);
    chk(rd, 0);
    apb(1'b1, OFS_STATUS, 32'hffff_ffff);
    chk(er, 1);
    apb(1'b0, OFS_MODE, 32'h0);
    chk(rd, 32'h2);
    finish_test();
  end
endmodule
